// [verilog/ltg_defines.svh]
// Constants for the long-mode task segment and task-gate decoder.
// Included by the design modules and the bench by bare name.
`ifndef LTG_DEFINES_SVH
`define LTG_DEFINES_SVH

//----------------------------------------
// Bus and response codes
//----------------------------------------
`define LTG_ADDR_W        8
`define LTG_RESP_OKAY     2'h0
`define LTG_RESP_SLVERR   2'h2

//----------------------------------------
// Register byte addresses
//----------------------------------------
`define LTG_OFF_IMG_LAST  8'h64
`define LTG_OFF_GATE_LO   8'h80
`define LTG_OFF_GATE_HI   8'h84
`define LTG_OFF_GATE_CMD  8'h88
`define LTG_OFF_GATE_STAT 8'h8C
`define LTG_OFF_IO_CMD    8'h90
`define LTG_OFF_IO_MAP    8'h94
`define LTG_OFF_IO_ADDR   8'h98
`define LTG_OFF_IO_STAT   8'h9C
`define LTG_OFF_PTR_SEL   8'hA0
`define LTG_OFF_PTR_LO    8'hA4
`define LTG_OFF_PTR_HI    8'hA8
`define LTG_OFF_CTRL      8'hB0

//----------------------------------------
// Segment image layout, in word indices
//----------------------------------------
`define LTG_IMG_WORDS     26
`define LTG_IDX_W         5
`define LTG_RSP_WORD      5'h01
`define LTG_IST_WORD      5'h09
`define LTG_MAP_WORD      5'h19
`define LTG_RSP_COUNT     3'h3
`define LTG_IST_COUNT     3'h7
`define LTG_MAP_LIMIT     16'hDFFF

//----------------------------------------
// Gate descriptor fields
//----------------------------------------
`define LTG_G_PRESENT     15
`define LTG_G_DPL_HI      14
`define LTG_G_DPL_LO      13
`define LTG_G_CLASS       12
`define LTG_G_TYPE_HI     11
`define LTG_G_TYPE_LO     8
`define LTG_G_SEL_HI      31
`define LTG_G_SEL_LO      16
`define LTG_TASK_GATE     5'h05

//----------------------------------------
// Control and command fields
//----------------------------------------
`define LTG_CTRL_MODE64   0
`define LTG_CTRL_LOAD     1
`define LTG_IO_SZ_HI      18
`define LTG_IO_SZ_LO      16
`define LTG_PTR_IST_BIT   3

`endif

// [verilog/ltg_pkg.sv]
// Types shared by the task segment decoder and its gate decoder.
// Assumes ltg_defines.svh on the include path.
package ltg_pkg;

    //----------------------------------------
    // Descriptor table holding a gate
    //----------------------------------------
    typedef enum logic [1:0] {
        LTG_TBL_GLOBAL    = 2'b00,
        LTG_TBL_LOCAL     = 2'b01,
        LTG_TBL_INTERRUPT = 2'b10,
        LTG_TBL_NONE      = 2'b11
    } ltg_table_e;

    //----------------------------------------
    // Write channel states
    //----------------------------------------
    typedef enum logic {
        LTG_WR_COLLECT = 1'b0,
        LTG_WR_RESP    = 1'b1
    } ltg_wr_state_e;

endpackage

// [verilog/ltg_gate_decode.sv]
// Combinational decoder for a task-gate descriptor pair of words.
// Assumes stable descriptor words held in registers by its parent.
`timescale 1ns/100ps
`default_nettype none
`include "ltg_defines.svh"

module ltg_gate_decode (
    // Descriptor words and source table
    input  wire logic [31:0]        gate_lo,
    input  wire logic [31:0]        gate_hi,
    input  wire ltg_pkg::ltg_table_e table_sel,
    // Decoded fields
    output logic                    table_ok,
    output logic                    is_task_gate,
    output logic                    present,
    output logic [1:0]              gate_privilege_level,
    output logic [15:0]             selector
);

    //----------------------------------------
    // Field extraction, reserved bits unused
    //----------------------------------------
    // Any of the three tables may hold a gate
    assign table_ok = (table_sel != ltg_pkg::LTG_TBL_NONE);
    // Class bit and type together mark a task gate
    assign is_task_gate = ({gate_hi[`LTG_G_CLASS],
                            gate_hi[`LTG_G_TYPE_HI:`LTG_G_TYPE_LO]}
                           == `LTG_TASK_GATE);
    assign present = gate_hi[`LTG_G_PRESENT];
    // Zero most privileged, three least
    assign gate_privilege_level = gate_hi[`LTG_G_DPL_HI:`LTG_G_DPL_LO];
    assign selector = gate_lo[`LTG_G_SEL_HI:`LTG_G_SEL_LO];

endmodule
`default_nettype wire

// [verilog/ltg_tss_gate.sv]
// AXI4-Lite register block decoding a long-mode task state segment
// image, a task-gate descriptor and I/O-permission map checks.
// Assumes one 25 MHz clock, synchronous active-low reset.
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "ltg_defines.svh"

module ltg_tss_gate (
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // Write address channel
    input  wire logic [`LTG_ADDR_W-1:0]  awaddr,
    input  wire logic                    awvalid,
    output logic                         awready,
    // Write data channel
    input  wire logic [31:0]             wdata,
    input  wire logic [3:0]              wstrb,
    input  wire logic                    wvalid,
    output logic                         wready,
    // Write response channel
    output logic [1:0]                   bresp,
    output logic                         bvalid,
    input  wire logic                    bready,
    // Read address channel
    input  wire logic [`LTG_ADDR_W-1:0]  araddr,
    input  wire logic                    arvalid,
    output logic                         arready,
    // Read data channel
    output logic [31:0]                  rdata,
    output logic [1:0]                   rresp,
    output logic                         rvalid,
    input  wire logic                    rready,
    // Fault pulses
    output logic                         not_present_fault,
    output logic                         io_gp_fault
);

    //----------------------------------------
    // Declarations
    //----------------------------------------
    logic [31:0]                tss_img [0:`LTG_IMG_WORDS-1];
    ltg_pkg::ltg_wr_state_e     wr_state_r, wr_state_nxt;
    logic                       aw_hold_r, aw_hold_nxt;
    logic                       w_hold_r, w_hold_nxt;
    logic [`LTG_ADDR_W-1:0]     aw_addr_r, aw_addr_nxt;
    logic [31:0]                w_data_r, w_data_nxt;
    logic [3:0]                 w_strb_r, w_strb_nxt;
    logic                       awready_r, awready_nxt;
    logic                       wready_r, wready_nxt;
    logic                       bvalid_r, bvalid_nxt;
    logic [1:0]                 bresp_r, bresp_nxt;
    logic                       arready_r, arready_nxt;
    logic                       rvalid_r, rvalid_nxt;
    logic [31:0]                rdata_r, rdata_nxt;
    logic [1:0]                 rresp_r, rresp_nxt;
    logic                       do_write;
    logic                       wr_mapped;
    logic                       img_wr;
    logic [31:0]                gate_lo_r, gate_lo_nxt;
    logic [31:0]                gate_hi_r, gate_hi_nxt;
    ltg_pkg::ltg_table_e        table_r, table_nxt;
    logic [31:0]                gate_stat_r, gate_stat_nxt;
    logic                       gate_go_r, gate_go_nxt;
    logic [31:0]                io_cmd_r, io_cmd_nxt;
    logic [31:0]                io_map_r, io_map_nxt;
    logic [31:0]                io_stat_r, io_stat_nxt;
    logic                       io_go_r, io_go_nxt;
    logic [3:0]                 ptr_sel_r, ptr_sel_nxt;
    logic                       mode64_r, mode64_nxt;
    logic                       loaded_r, loaded_nxt;
    logic                       np_fault_r, np_fault_nxt;
    logic                       gp_fault_r, gp_fault_nxt;
    logic                       g_table_ok;
    logic                       g_task;
    logic                       g_present;
    logic [1:0]                 g_dpl;
    logic [15:0]                g_sel;
    logic                       g_accept;
    logic [15:0]                map_base;
    logic [16:0]                map_byte;
    logic [3:0]                 size_mask;
    logic [15:0]                port_mask;
    logic                       io_fault;
    logic [`LTG_IDX_W-1:0]      ptr_word;
    logic                       ptr_ok;
    logic [31:0]                ptr_lo;
    logic [31:0]                ptr_hi;

    //----------------------------------------
    // Byte-lane merge for strobed writes
    //----------------------------------------
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (strb[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    //----------------------------------------
    // Gate descriptor decoder
    //----------------------------------------
    ltg_gate_decode u_gate (
        .gate_lo              (gate_lo_r),
        .gate_hi              (gate_hi_r),
        .table_sel            (table_r),
        .table_ok             (g_table_ok),
        .is_task_gate         (g_task),
        .present              (g_present),
        .gate_privilege_level (g_dpl),
        .selector             (g_sel)
    );
    assign g_accept = g_table_ok & g_task;

    //----------------------------------------
    // Segment field lookup
    //----------------------------------------
    // Map offset lives in the upper half of the last word
    assign map_base = tss_img[`LTG_MAP_WORD][31:16];
    assign map_byte = {1'b0, map_base} + {4'h0, io_cmd_r[15:3]};
    // Pointer word index, each pointer two words
    always_comb
    begin
        ptr_word = `LTG_RSP_WORD;
        ptr_ok   = 1'b0;
        if (!ptr_sel_r[`LTG_PTR_IST_BIT])
        begin
            ptr_word = `LTG_RSP_WORD + {1'b0, ptr_sel_r[2:0], 1'b0};
            ptr_ok   = (ptr_sel_r[2:0] < `LTG_RSP_COUNT);
        end
        else
        begin
            ptr_word = `LTG_IST_WORD + {1'b0, ptr_sel_r[2:0] - 3'h1, 1'b0};
            ptr_ok   = (ptr_sel_r[2:0] != 3'h0) && (ptr_sel_r[2:0] <= `LTG_IST_COUNT);
        end
    end
    // Low half at lower address; nothing until a segment is loaded
    assign ptr_lo = (ptr_ok && loaded_r) ? tss_img[ptr_word] : 32'h0;
    assign ptr_hi = (ptr_ok && loaded_r) ? tss_img[ptr_word + 5'h01] : 32'h0;

    //----------------------------------------
    // I/O permission check
    //----------------------------------------
    always_comb
    begin
        case (io_cmd_r[`LTG_IO_SZ_HI:`LTG_IO_SZ_LO])
            3'h1: size_mask = 4'h1;
            3'h2: size_mask = 4'h3;
            3'h4: size_mask = 4'hF;
            default: size_mask = 4'h0;
        endcase
    end
    assign port_mask = {12'h000, size_mask} << io_cmd_r[2:0];
    // Any covering bit set, bad size or map too high faults
    assign io_fault = (size_mask == 4'h0)
                    | (|(io_map_r[15:0] & port_mask))
                    | (map_base > `LTG_MAP_LIMIT);

    //----------------------------------------
    // Bus channel next state
    //----------------------------------------
    always_comb
    begin
        wr_state_nxt = wr_state_r;
        aw_hold_nxt  = aw_hold_r | (awvalid & awready_r);
        w_hold_nxt   = w_hold_r | (wvalid & wready_r);
        aw_addr_nxt  = (awvalid & awready_r) ? awaddr : aw_addr_r;
        w_data_nxt   = (wvalid & wready_r) ? wdata : w_data_r;
        w_strb_nxt   = (wvalid & wready_r) ? wstrb : w_strb_r;
        bvalid_nxt   = bvalid_r;
        bresp_nxt    = bresp_r;
        do_write     = 1'b0;
        case (wr_state_r)
            ltg_pkg::LTG_WR_COLLECT:
            begin
                if (aw_hold_r && w_hold_r)
                begin
                    do_write     = 1'b1;
                    aw_hold_nxt  = 1'b0;
                    w_hold_nxt   = 1'b0;
                    bvalid_nxt   = 1'b1;
                    bresp_nxt    = wr_mapped ? `LTG_RESP_OKAY : `LTG_RESP_SLVERR;
                    wr_state_nxt = ltg_pkg::LTG_WR_RESP;
                end
            end
            ltg_pkg::LTG_WR_RESP:
            begin
                if (bready)
                begin
                    bvalid_nxt   = 1'b0;
                    wr_state_nxt = ltg_pkg::LTG_WR_COLLECT;
                end
            end
            default: wr_state_nxt = ltg_pkg::LTG_WR_COLLECT;
        endcase
        awready_nxt = !aw_hold_nxt && !bvalid_nxt;
        wready_nxt  = !w_hold_nxt && !bvalid_nxt;
        // Read: one cycle answer, address taken only when idle
        rvalid_nxt  = rvalid_r;
        arready_nxt = arready_r;
        rdata_nxt   = rdata_r;
        rresp_nxt   = rresp_r;
        if (rvalid_r && rready)
        begin
            rvalid_nxt  = 1'b0;
            arready_nxt = 1'b1;
        end
        else if (arvalid && arready_r)
        begin
            rvalid_nxt  = 1'b1;
            arready_nxt = 1'b0;
            rresp_nxt   = `LTG_RESP_OKAY;
            if (araddr <= `LTG_OFF_IMG_LAST && araddr[1:0] == 2'h0)
                rdata_nxt = tss_img[araddr[6:2]];
            else if (araddr == `LTG_OFF_GATE_LO)
                rdata_nxt = gate_lo_r;
            else if (araddr == `LTG_OFF_GATE_HI)
                rdata_nxt = gate_hi_r;
            else if (araddr == `LTG_OFF_GATE_CMD)
                rdata_nxt = {30'h0, table_r};
            else if (araddr == `LTG_OFF_GATE_STAT)
                rdata_nxt = gate_stat_r;
            else if (araddr == `LTG_OFF_IO_CMD)
                rdata_nxt = io_cmd_r;
            else if (araddr == `LTG_OFF_IO_MAP)
                rdata_nxt = io_map_r;
            else if (araddr == `LTG_OFF_IO_ADDR)
                rdata_nxt = {15'h0, map_byte};
            else if (araddr == `LTG_OFF_IO_STAT)
                rdata_nxt = io_stat_r;
            else if (araddr == `LTG_OFF_PTR_SEL)
                rdata_nxt = {28'h0, ptr_sel_r};
            else if (araddr == `LTG_OFF_PTR_LO)
                rdata_nxt = ptr_lo;
            else if (araddr == `LTG_OFF_PTR_HI)
                rdata_nxt = ptr_hi;
            else if (araddr == `LTG_OFF_CTRL)
                rdata_nxt = {30'h0, loaded_r, mode64_r};
            else
            begin
                rdata_nxt = 32'h0;
                rresp_nxt = `LTG_RESP_SLVERR;
            end
        end
    end

    //----------------------------------------
    // Write address decode
    //----------------------------------------
    assign img_wr = (aw_addr_r <= `LTG_OFF_IMG_LAST) && (aw_addr_r[1:0] == 2'h0);
    assign wr_mapped = img_wr
                     || (aw_addr_r == `LTG_OFF_GATE_LO)
                     || (aw_addr_r == `LTG_OFF_GATE_HI)
                     || (aw_addr_r == `LTG_OFF_GATE_CMD)
                     || (aw_addr_r == `LTG_OFF_IO_CMD)
                     || (aw_addr_r == `LTG_OFF_IO_MAP)
                     || (aw_addr_r == `LTG_OFF_PTR_SEL)
                     || (aw_addr_r == `LTG_OFF_CTRL);

    //----------------------------------------
    // Control and status next state
    //----------------------------------------
    always_comb
    begin
        gate_lo_nxt   = gate_lo_r;
        gate_hi_nxt   = gate_hi_r;
        table_nxt     = table_r;
        gate_go_nxt   = 1'b0;
        io_cmd_nxt    = io_cmd_r;
        io_map_nxt    = io_map_r;
        io_go_nxt     = 1'b0;
        ptr_sel_nxt   = ptr_sel_r;
        mode64_nxt    = mode64_r;
        loaded_nxt    = loaded_r;
        gate_stat_nxt = gate_stat_r;
        io_stat_nxt   = io_stat_r;
        np_fault_nxt  = 1'b0;
        gp_fault_nxt  = 1'b0;
        if (do_write)
        begin
            if (aw_addr_r == `LTG_OFF_GATE_LO)
                gate_lo_nxt = merge(gate_lo_r, w_data_r, w_strb_r);
            else if (aw_addr_r == `LTG_OFF_GATE_HI)
                gate_hi_nxt = merge(gate_hi_r, w_data_r, w_strb_r);
            else if (aw_addr_r == `LTG_OFF_GATE_CMD)
            begin
                table_nxt   = ltg_pkg::ltg_table_e'(w_data_r[1:0]);
                gate_go_nxt = 1'b1;
            end
            else if (aw_addr_r == `LTG_OFF_IO_CMD)
            begin
                io_cmd_nxt = merge(io_cmd_r, w_data_r, w_strb_r);
                io_go_nxt  = 1'b1;
            end
            else if (aw_addr_r == `LTG_OFF_IO_MAP)
                io_map_nxt = merge(io_map_r, w_data_r, w_strb_r);
            else if (aw_addr_r == `LTG_OFF_PTR_SEL)
                ptr_sel_nxt = w_data_r[3:0];
            else if (aw_addr_r == `LTG_OFF_CTRL)
            begin
                mode64_nxt = w_data_r[`LTG_CTRL_MODE64];
                // Pointer register load honoured only in 64-bit mode
                if (w_data_r[`LTG_CTRL_LOAD])
                    loaded_nxt = w_data_r[`LTG_CTRL_MODE64];
            end
        end
        // Gate result, descriptor words left as written
        if (gate_go_r)
        begin
            gate_stat_nxt = {g_sel, 10'h0, g_table_ok, g_task, g_dpl,
                             g_accept & !g_present, g_accept & g_present};
            np_fault_nxt  = g_accept & !g_present;
        end
        // Permission result
        if (io_go_r)
        begin
            io_stat_nxt  = {29'h0, io_fault, !io_fault, 1'b1};
            gp_fault_nxt = io_fault;
        end
    end

    //----------------------------------------
    // Segment image store, bus writes only
    //----------------------------------------
    // The block itself never writes state back here
    always_ff @(posedge aclk)
    begin
        if (do_write && img_wr)
            tss_img[aw_addr_r[6:2]] <= merge(tss_img[aw_addr_r[6:2]],
                                             w_data_r, w_strb_r);
    end

    //----------------------------------------
    // Registers
    //----------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_state_r  <= ltg_pkg::LTG_WR_COLLECT;
            aw_hold_r   <= 1'b0;
            w_hold_r    <= 1'b0;
            aw_addr_r   <= 8'h00;
            w_data_r    <= 32'h0;
            w_strb_r    <= 4'h0;
            awready_r   <= 1'b1;
            wready_r    <= 1'b1;
            bvalid_r    <= 1'b0;
            bresp_r     <= `LTG_RESP_OKAY;
            arready_r   <= 1'b1;
            rvalid_r    <= 1'b0;
            rdata_r     <= 32'h0;
            rresp_r     <= `LTG_RESP_OKAY;
            gate_lo_r   <= 32'h0;
            gate_hi_r   <= 32'h0;
            table_r     <= ltg_pkg::LTG_TBL_GLOBAL;
            gate_stat_r <= 32'h0;
            gate_go_r   <= 1'b0;
            io_cmd_r    <= 32'h0;
            io_map_r    <= 32'h0;
            io_stat_r   <= 32'h0;
            io_go_r     <= 1'b0;
            ptr_sel_r   <= 4'h0;
            mode64_r    <= 1'b0;
            loaded_r    <= 1'b0;
            np_fault_r  <= 1'b0;
            gp_fault_r  <= 1'b0;
        end
        else
        begin
            wr_state_r  <= wr_state_nxt;
            aw_hold_r   <= aw_hold_nxt;
            w_hold_r    <= w_hold_nxt;
            aw_addr_r   <= aw_addr_nxt;
            w_data_r    <= w_data_nxt;
            w_strb_r    <= w_strb_nxt;
            awready_r   <= awready_nxt;
            wready_r    <= wready_nxt;
            bvalid_r    <= bvalid_nxt;
            bresp_r     <= bresp_nxt;
            arready_r   <= arready_nxt;
            rvalid_r    <= rvalid_nxt;
            rdata_r     <= rdata_nxt;
            rresp_r     <= rresp_nxt;
            gate_lo_r   <= gate_lo_nxt;
            gate_hi_r   <= gate_hi_nxt;
            table_r     <= table_nxt;
            gate_stat_r <= gate_stat_nxt;
            gate_go_r   <= gate_go_nxt;
            io_cmd_r    <= io_cmd_nxt;
            io_map_r    <= io_map_nxt;
            io_stat_r   <= io_stat_nxt;
            io_go_r     <= io_go_nxt;
            ptr_sel_r   <= ptr_sel_nxt;
            mode64_r    <= mode64_nxt;
            loaded_r    <= loaded_nxt;
            np_fault_r  <= np_fault_nxt;
            gp_fault_r  <= gp_fault_nxt;
        end
    end

    //----------------------------------------
    // Outputs
    //----------------------------------------
    assign awready           = awready_r;
    assign wready            = wready_r;
    assign bvalid            = bvalid_r;
    assign bresp             = bresp_r;
    assign arready           = arready_r;
    assign rvalid            = rvalid_r;
    assign rdata             = rdata_r;
    assign rresp             = rresp_r;
    assign not_present_fault = np_fault_r;
    assign io_gp_fault       = gp_fault_r;

endmodule
`default_nettype wire

// [bench/ltg_sw_img.sv]
// Software model: builds the 64-bit task state segment image.
// Assumes the bench copies each word into the block before use.
`timescale 1ns/100ps
`default_nettype none
module ltg_sw_img (
    // Image words, byte offset four times the index
    output logic [31:0] img [26]
);
    // Distinct words, junk in reserved slots, map base 68h
    always_comb
    begin
        for (int k = 0; k < 26; k++)
            img[k] = {k[7:0], 8'h5A, ~k[7:0], 8'hC3};
        img[25] = 32'h0068_BEEF;
    end
endmodule
`default_nettype wire

// [bench/ltg_tss_gate_chk.sv]
// Checker: bus handshakes and fault pulses of the decoder.
// Assumes binding to the top module by port name.
`timescale 1ns/100ps
`default_nettype none
module ltg_tss_gate_chk (
    // Clock, reset and bus
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        awvalid,
    input wire logic        awready,
    input wire logic        wvalid,
    input wire logic        wready,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    // Fault pulses
    input wire logic        not_present_fault,
    input wire logic        io_gp_fault
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Answers stand until taken, no overlap
    a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read answer dropped");
    a_aw_block: assert property (bvalid |-> !awready && !wready)
        else $error("write taken early");
    a_ar_block: assert property (rvalid |-> !arready)
        else $error("read taken early");
    // Answer latency and pulse width
    a_wr_lat: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write answer late");
    a_rd_lat: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_np_pulse: assert property ($rose(not_present_fault) |=> $fell(not_present_fault))
        else $error("fault pulse long");
    a_gp_pulse: assert property (io_gp_fault |=> !io_gp_fault)
        else $error("io pulse long");
    c_np: cover property (not_present_fault);
    c_gp: cover property (io_gp_fault);
    c_err: cover property (bvalid && bresp == 2'h2);
endmodule
bind ltg_tss_gate ltg_tss_gate_chk chk_i (.aclk, .aresetn, .awvalid, .awready, .wvalid,
    .wready, .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .rdata,
    .not_present_fault, .io_gp_fault);
`default_nettype wire

// [bench/tb.sv]
// Bench: register bus tests of the segment and gate decoder.
// Assumes the image model, checker and design compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ltg_defines.svh"
module tb;
    logic aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid, np_f, gp_f;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, r;
    logic [31:0] wdata = 32'h0, rdata, d, hi, img [26];
    logic [15:0] pt;
    logic [2:0] sz [4] = '{3'h1, 3'h2, 3'h4, 3'h3};
    logic [15:0] mp [4] = '{16'hFFF7, 16'hFFF7, 16'hFC3F, 16'h0000};
    logic ok, tm, ps;
    int n_mismatch = 0, cmp_count = 0, np_n = 0, gp_n = 0, k;
    ltg_sw_img sw (.img(img));
    ltg_tss_gate uut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .not_present_fault(np_f), .io_gp_fault(gp_f));
    // Clock and fault pulse counts
    always #20 aclk = ~aclk;
    always @(posedge aclk)
    begin
        np_n += np_f;
        gp_n += gp_f;
    end
    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // Bus write and read, each bounded
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int i;
        awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        for (i = 0; i < 64; i++)
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
        bready <= 1'b0;
        @(posedge aclk);
        if (i == 64) begin n_mismatch++; final_report(); end
    endtask
    task automatic rd(input logic [7:0] a);
        int i;
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (i = 0; i < 64; i++)
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata; r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
        if (i == 64) begin n_mismatch++; final_report(); end
    endtask
    initial
    begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`LTG_OFF_PTR_LO);
        chk(d, 32'h0);
        // Image load, then load in 64-bit mode
        for (k = 0; k < 26; k++) wr(8'(k * 4), img[k]);
        wr(`LTG_OFF_CTRL, 32'h3);
        rd(`LTG_OFF_CTRL);
        chk(d, 32'h3);
        // Stack pointers, then interrupt stack entries
        for (k = 0; k < 10; k++)
        begin
            wr(`LTG_OFF_PTR_SEL, (k < 3) ? 32'(k) : 32'(k + 6));
            rd(`LTG_OFF_PTR_LO);
            chk(d, img[(k < 3) ? 2 * k + 1 : 2 * k + 3]);
            rd(`LTG_OFF_PTR_HI);
            chk(d, img[(k < 3) ? 2 * k + 2 : 2 * k + 4]);
        end
        // Gate over every table, absent, present and wrong type
        for (k = 0; k < 8; k++)
        begin
            ok = (k % 4) != 3;
            tm = k != 6;
            ps = k >= 4;
            hi = {16'hA55A, ps, 2'(k), 1'b0, tm ? 4'h5 : 4'h4, 8'h3C};
            wr(`LTG_OFF_GATE_LO, {16'h1230 + 16'(k), 16'hFFFF});
            wr(`LTG_OFF_GATE_HI, hi);
            wr(`LTG_OFF_GATE_CMD, 32'(k % 4));
            repeat (2) @(posedge aclk);
            rd(`LTG_OFF_GATE_STAT);
            chk(d, {16'h1230 + 16'(k), 10'h0, ok, tm, 2'(k), ok & tm & !ps, ok & tm & ps});
            rd(`LTG_OFF_GATE_HI);
            chk(d, hi);
        end
        chk(32'(np_n), 32'h3);
        // Port checks, one across a map byte, one bad size
        for (k = 0; k < 4; k++)
        begin
            pt = (k < 2) ? 16'h0443 : 16'h0446;
            ps = sz[k] != 3'h3 && ((32'(mp[k]) >> pt[2:0]) & ((32'h1 << sz[k]) - 1)) == 0;
            wr(`LTG_OFF_IO_MAP, 32'(mp[k]));
            wr(`LTG_OFF_IO_CMD, {13'h0, sz[k], pt});
            repeat (2) @(posedge aclk);
            rd(`LTG_OFF_IO_STAT);
            chk(d, {29'h0, !ps, ps, 1'b1});
            rd(`LTG_OFF_IO_ADDR);
            chk(d, 32'h68 + 32'(pt >> 3));
        end
        chk(32'(gp_n), 32'h2);
        wr(8'h64, 32'hE000_0000);
        wr(`LTG_OFF_IO_CMD, 32'h0001_0000);
        rd(`LTG_OFF_IO_STAT);
        chk(d, 32'h5);
        // Image untouched, unmapped read, read-only write
        rd(8'h24);
        chk(d, img[9]);
        rd(8'hFC);
        chk(d, 32'h0);
        chk(32'(r), 32'h2);
        wr(`LTG_OFF_IO_STAT, 32'hFFFF);
        chk(32'(r), 32'h2);
        wr(`LTG_OFF_CTRL, 32'h2);
        rd(`LTG_OFF_CTRL);
        chk(d, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
